//--- pkg/dlcd_pkg.sv
// Purpose: shared constants and types for the display-list draw decoder
// Assumes: 32-bit display-list words, APB register access
// Notes:   header word is opcode[31:24], command[23:16], low field[15:0]
package dlcd_pkg;

  // header opcodes of the decoded commands
  localparam logic [7:0] OP_DRAW   = 8'h10;
  localparam logic [7:0] OP_TRAP   = 8'h20;
  localparam logic [7:0] OP_VTX    = 8'h30;
  localparam logic [7:0] OP_VTXP   = 8'h31;
  localparam logic [7:0] OP_LINEP  = 8'h40;
  localparam logic [7:0] OP_RECTP  = 8'h50;
  localparam logic [7:0] OP_PATP   = 8'h51;
  localparam logic [7:0] OP_LPATP  = 8'h52;

  // command field codes
  localparam logic [2:0] CMD_LINE_GRP     = 3'h1;
  localparam int         LINE_REV_BIT     = 0;
  localparam int         LINE_SKIP_BIT    = 1;
  localparam int         LINE_DASH_BIT    = 2;
  localparam int         LINE_SMOOTH_BIT  = 4;
  localparam logic [7:0] CMD_SOLID_FILL   = 8'h41;
  localparam logic [7:0] CMD_BLOCK_PAT    = 8'h42;
  localparam logic [7:0] CMD_BIN_CHAR     = 8'h43;
  localparam logic [7:0] CMD_TRAP_RIGHT   = 8'h60;
  localparam logic [7:0] CMD_TRAP_LEFT    = 8'h61;
  localparam logic [7:0] CMD_FAN          = 8'h62;
  localparam logic [7:0] CMD_FLAG_FAN     = 8'h63;
  localparam logic [7:0] CMD_SHAPE_FINISH = 8'he1;
  localparam logic [7:0] CMD_FLAG_CLEAR   = 8'he2;

  // parameter words taken by each format
  localparam logic [3:0] NPRM_LINE = 4'h1;
  localparam logic [3:0] NPRM_TRAP = 4'h9;
  localparam logic [3:0] NPRM_VTX  = 4'h2;
  localparam logic [3:0] NPRM_VTXP = 4'h1;
  localparam logic [3:0] NPRM_RECT = 4'h2;
  localparam logic [3:0] NPRM_LPAT = 4'h3;

  // register byte offsets, reset values and control bits
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_COLOR  = 8'h04;
  localparam logic [7:0]  REG_FG     = 8'h08;
  localparam logic [7:0]  REG_BG     = 8'h0c;
  localparam logic [7:0]  REG_FRAME_X_RES = 8'h10;
  localparam logic [7:0]  REG_STATUS = 8'h14;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0001;
  localparam logic [15:0] FRAME_X_RES_RST = 16'h0000;
  localparam int          CTRL_EN_BIT     = 0;
  localparam int          CTRL_BPP16_BIT  = 1;
  localparam int          CTRL_TRANSP_BIT = 2;

  typedef enum logic [3:0] {
    ST_HDR   = 4'b0001,
    ST_PRM   = 4'b0010,
    ST_ISSUE = 4'b0100,
    ST_PAT   = 4'b1000
  } dlcd_state_t;

  typedef enum logic [2:0] {
    PK_NONE, PK_LINE, PK_TRAP, PK_FAN, PK_RECT, PK_PAT, PK_FINISH
  } dlcd_kind_t;

  typedef struct packed {
    dlcd_kind_t  kind;
    logic        reverse;
    logic        skip_last;
    logic        dash_restart;
    logic        smooth;
    logic        left_tri;
    logic        to_flag_buf;
    logic        flag_clear;
    logic        ignore_clip;
    logic        binary_char;
    logic        bpp16;
    logic        transparent_bg;
    logic [15:0] frame_x_resolution;
    logic [31:0] color;
    logic [31:0] fg;
    logic [31:0] bg;
  } dlcd_prim_t;

  typedef struct packed {
    logic       ok;
    logic [3:0] nprm;
    logic       cnt_in_hdr;
    logic       cnt_in_prm;
    dlcd_prim_t prim;
  } dlcd_dec_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } dlcd_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } dlcd_apb_rsp_t;

endpackage

//--- rtl/dlcd_decoder.sv
// Purpose: decode display-list draw commands into primitives and patterns
// Assumes: one clock, synchronous active-high reset, APB register access
// Notes:   pattern words leave one at a time through a one-word slot
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module dlcd_decoder
  import dlcd_pkg::*;
#(
  parameter int PRM_WORDS = 9
)(
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire dlcd_apb_req_t           apb_req,
  output dlcd_apb_rsp_t                apb_rsp,
  input  wire logic                    dl_valid,
  input  wire logic [31:0]             dl_word,
  output logic                         dl_ready,
  output logic                         prim_valid,
  input  wire logic                    prim_ready,
  output dlcd_prim_t                   prim,
  output logic [PRM_WORDS-1:0][31:0]   prm,
  output logic                         pat_valid,
  output logic [31:0]                  pat_data,
  input  wire logic                    pat_ready
);

  // the trapezoid format needs the largest parameter file
  if (PRM_WORDS < int'(NPRM_TRAP))
  begin : g_chk
    $error("PRM_WORDS too small for the trapezoid format");
  end

  dlcd_state_t st_r, st_nxt;
  dlcd_dec_t   dec_w, dec_r;
  dlcd_prim_t  prim_r, prim_nxt;
  logic [31:0] prm_r [PRM_WORDS];
  logic [31:0] ctrl_r, color_r, fg_r, bg_r, rd_mux;
  logic [15:0] frame_x_res_r;
  logic [7:0]  bad_cnt_r, hdr_cmd_r;
  logic [3:0]  prm_idx_r;
  logic [31:0] pat_left_r;
  logic        dl_ready_r, dl_ready_nxt, prim_valid_r, prim_valid_nxt;
  logic        pat_valid_r, pat_valid_nxt;
  logic [31:0] pat_data_r, prdata_r;
  logic        pready_r, pslverr_r, reg_hit;
  logic        acc, prm_last, go_issue, apb_acc, apb_wr;

  // header decode: kind, options and parameter word count
  function automatic dlcd_dec_t dlcd_decode(input logic [31:0] h);
    dlcd_dec_t  d;
    logic [7:0] cmd;
    d = '0;
    cmd = h[23:16];
    case (h[31:24])
      OP_LINEP:
      begin
        d.prim.kind         = PK_LINE;
        d.nprm              = NPRM_LINE;
        d.ok                = (cmd[7:5] == CMD_LINE_GRP);
        d.prim.reverse      = cmd[LINE_REV_BIT];
        d.prim.skip_last    = cmd[LINE_SKIP_BIT];
        d.prim.dash_restart = cmd[LINE_DASH_BIT];
        d.prim.smooth       = cmd[LINE_SMOOTH_BIT];
      end
      OP_TRAP:
      begin
        d.prim.kind     = PK_TRAP;
        d.nprm          = NPRM_TRAP;
        d.prim.left_tri = (cmd == CMD_TRAP_LEFT);
        d.ok = (cmd == CMD_TRAP_LEFT) || (cmd == CMD_TRAP_RIGHT);
      end
      OP_VTX, OP_VTXP:
      begin
        d.prim.kind        = PK_FAN;
        d.nprm             = (h[31:24] == OP_VTXP) ? NPRM_VTXP : NPRM_VTX;
        d.prim.to_flag_buf = (cmd == CMD_FLAG_FAN);
        d.ok = (cmd == CMD_FAN) || (cmd == CMD_FLAG_FAN);
      end
      OP_RECTP:
      begin
        d.prim.kind        = PK_RECT;
        d.nprm             = NPRM_RECT;
        d.prim.ignore_clip = 1'b1;
        d.prim.flag_clear  = (cmd == CMD_FLAG_CLEAR);
        d.ok = (cmd == CMD_SOLID_FILL) || (cmd == CMD_FLAG_CLEAR);
      end
      OP_PATP:
      begin
        d.prim.kind        = PK_PAT;
        d.nprm             = NPRM_RECT;
        d.cnt_in_hdr       = 1'b1;
        d.prim.binary_char = (cmd == CMD_BIN_CHAR);
        d.ok = (cmd == CMD_BLOCK_PAT) || (cmd == CMD_BIN_CHAR);
      end
      OP_LPATP:
      begin
        d.prim.kind = PK_PAT;
        d.nprm      = NPRM_LPAT;
        d.cnt_in_prm = 1'b1;
        d.ok = (cmd == CMD_BLOCK_PAT);
      end
      OP_DRAW:
      begin
        d.prim.kind = PK_FINISH;
        d.ok = (cmd == CMD_SHAPE_FINISH);
      end
      default:
      begin
        d.ok = 1'b0;
      end
    endcase
    return d;
  endfunction

  // handshake terms of the display-list stream
  assign dec_w    = dlcd_decode(dl_word);
  assign acc      = dl_valid && dl_ready_r;
  assign prm_last = (prm_idx_r == dec_r.nprm - 4'h1);
  assign go_issue = acc && ((st_r == ST_HDR && dec_w.ok && dec_w.nprm == 4'h0)
                    || (st_r == ST_PRM && prm_last));

  // next state; every format walks its own word count
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      ST_HDR:
        if (acc && dec_w.ok)
          st_nxt = (dec_w.nprm == 4'h0) ? ST_ISSUE : ST_PRM;
      ST_PRM:
        if (acc && prm_last)
          st_nxt = ST_ISSUE;
      ST_ISSUE:
        if (prim_valid_r && prim_ready)
          st_nxt = (pat_left_r != 32'h0) ? ST_PAT : ST_HDR;
      ST_PAT:
        if (acc && pat_left_r == 32'h1)
          st_nxt = ST_HDR;
      default:
        st_nxt = ST_HDR;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      st_r <= ST_HDR;
    else
      st_r <= st_nxt;
  end

  // header capture, parameter index, bad header count
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      dec_r     <= '0;
      hdr_cmd_r <= 8'h00;
      prm_idx_r <= 4'h0;
      bad_cnt_r <= 8'h00;
    end
    else if (acc && st_r == ST_HDR)
    begin
      prm_idx_r <= 4'h0;
      if (dec_w.ok)
      begin
        dec_r     <= dec_w;
        hdr_cmd_r <= dl_word[23:16];
      end
      else
        bad_cnt_r <= bad_cnt_r + 8'h01; // one word dropped per bad header
    end
    else if (acc && st_r == ST_PRM)
      prm_idx_r <= prm_idx_r + 4'h1;
  end

  // parameter words go into the drawing registers in arrival order
  always_ff @(posedge clock)
  begin
    if (rst)
      prm_r <= '{default: 32'h0};
    else if (acc && st_r == ST_PRM)
      prm_r[prm_idx_r] <= dl_word;
  end

  // pattern count from the header or from a signed count word
  always_ff @(posedge clock)
  begin
    if (rst)
      pat_left_r <= 32'h0;
    else if (acc && st_r == ST_HDR)
      pat_left_r <= dec_w.cnt_in_hdr ? {16'h0, dl_word[15:0]} : 32'h0;
    else if (acc && st_r == ST_PRM && dec_r.cnt_in_prm && prm_idx_r == 4'h0)
      pat_left_r <= dl_word[31] ? 32'h0 : {1'b0, dl_word[30:0]};
    else if (acc && st_r == ST_PAT)
      pat_left_r <= pat_left_r - 32'h1;
  end

  // primitive descriptor, colours sampled when the command issues
  always_comb
  begin
    prim_nxt = (st_r == ST_HDR) ? dec_w.prim : dec_r.prim;
    prim_nxt.color          = color_r;
    prim_nxt.fg             = fg_r;
    prim_nxt.bg             = bg_r;
    prim_nxt.bpp16          = ctrl_r[CTRL_BPP16_BIT];
    prim_nxt.transparent_bg = ctrl_r[CTRL_TRANSP_BIT];
    prim_nxt.frame_x_resolution = frame_x_res_r;
  end

  // issue holds until the pipeline takes it
  assign prim_valid_nxt = go_issue || (prim_valid_r && !prim_ready);

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      prim_valid_r <= 1'b0;
      prim_r       <= '0;
    end
    else
    begin
      prim_valid_r <= prim_valid_nxt;
      if (go_issue)
        prim_r <= prim_nxt;
    end
  end

  // one-word pattern slot toward graphics memory
  assign pat_valid_nxt = (pat_valid_r && !pat_ready) || (acc && st_r == ST_PAT);

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pat_valid_r <= 1'b0;
      pat_data_r  <= 32'h0;
    end
    else
    begin
      pat_valid_r <= pat_valid_nxt;
      if (acc && st_r == ST_PAT)
        pat_data_r <= dl_word;
    end
  end

  // registered ready; low during issue and while a pattern word waits,
  // which also keeps the next header behind the last pattern word
  assign dl_ready_nxt = ctrl_r[CTRL_EN_BIT] && !pat_valid_nxt
                        && (st_nxt != ST_ISSUE);

  always_ff @(posedge clock)
  begin
    if (rst)
      dl_ready_r <= 1'b0;
    else
      dl_ready_r <= dl_ready_nxt;
  end

  // apb: one wait state, writes land on the pready edge
  assign apb_acc = apb_req.psel && apb_req.penable;
  assign apb_wr  = apb_acc && pready_r && apb_req.pwrite && reg_hit;

  always_comb
  begin
    reg_hit = 1'b1;
    rd_mux  = 32'h0;
    case (apb_req.paddr)
      REG_CTRL:   rd_mux = ctrl_r;
      REG_COLOR:  rd_mux = color_r;
      REG_FG:     rd_mux = fg_r;
      REG_BG:     rd_mux = bg_r;
      REG_FRAME_X_RES: rd_mux = {16'h0, frame_x_res_r};
      REG_STATUS: rd_mux = {16'h0, bad_cnt_r, 2'b00, pat_valid_r,
                            prim_valid_r, st_r};
      default:    reg_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
    end
    else
    begin
      pready_r <= apb_acc && !pready_r;
      if (apb_acc && !pready_r)
      begin
        pslverr_r <= !reg_hit;
        prdata_r  <= apb_req.pwrite ? 32'h0 : rd_mux;
      end
    end
  end

  // software-written settings; status is read-only
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ctrl_r  <= CTRL_RST;
      color_r <= 32'h0;
      fg_r    <= 32'h0;
      bg_r    <= 32'h0;
      frame_x_res_r <= FRAME_X_RES_RST;
    end
    else if (apb_wr)
    begin
      case (apb_req.paddr)
        REG_CTRL:  ctrl_r  <= apb_req.pwdata;
        REG_COLOR: color_r <= apb_req.pwdata;
        REG_FG:    fg_r    <= apb_req.pwdata;
        REG_BG:    bg_r    <= apb_req.pwdata;
        REG_FRAME_X_RES: frame_x_res_r <= apb_req.pwdata[15:0];
        default:   ctrl_r  <= ctrl_r;
      endcase
    end
  end

  // outputs straight from flops
  assign apb_rsp    = '{prdata: prdata_r, pready: pready_r, pslverr: pslverr_r};
  assign dl_ready   = dl_ready_r;
  assign prim_valid = prim_valid_r;
  assign prim       = prim_r;
  assign pat_valid  = pat_valid_r;
  assign pat_data   = pat_data_r;

  // one process drives the whole packed port; per-element assigns would
  // be several continuous drivers on one variable
  always_comb
  begin
    for (int i = 0; i < PRM_WORDS; i++)
      prm[i] = prm_r[i];
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  line_dir_a: assert property (
    prim_valid_r && prim_r.kind == PK_LINE
    |-> prim_r.reverse == hdr_cmd_r[LINE_REV_BIT])
    else $error("line direction not taken from command");
  skip_last_a: assert property (
    prim_valid_r && prim_r.kind == PK_LINE
    |-> prim_r.skip_last == hdr_cmd_r[LINE_SKIP_BIT])
    else $error("skip-last option lost");
  dash_smooth_a: assert property (
    prim_valid_r && prim_r.kind == PK_LINE
    |-> prim_r.dash_restart == hdr_cmd_r[LINE_DASH_BIT]
        && prim_r.smooth == hdr_cmd_r[LINE_SMOOTH_BIT])
    else $error("dash or smooth option lost");
  issue_loaded_a: assert property (
    $rose(prim_valid_r) && prim_r.kind != PK_FINISH
    |-> $past(st_r) == ST_PRM && $past(acc) && $past(prm_last))
    else $error("primitive issued before parameters loaded");
  line_word_a: assert property (
    acc && st_r == ST_PRM && dec_r.prim.kind == PK_LINE
    |=> prm_r[0] == $past(dl_word) && prim_valid_r)
    else $error("packed line word not loaded");
  trap_side_a: assert property (
    prim_valid_r && prim_r.kind == PK_TRAP
    |-> prim_r.left_tri == (hdr_cmd_r == CMD_TRAP_LEFT))
    else $error("trapezoid side wrong");
  flag_fan_a: assert property (
    prim_valid_r && prim_r.kind == PK_FAN
    |-> prim_r.to_flag_buf == (hdr_cmd_r == CMD_FLAG_FAN))
    else $error("flag fan target wrong");
  rect_clip_a: assert property (
    prim_valid_r && prim_r.kind == PK_RECT |-> prim_r.ignore_clip)
    else $error("rectangle fill clipped");
  pipe_stall_a: assert property (
    prim_valid_r && !prim_ready |=> prim_valid_r && !dl_ready_r)
    else $error("fetch continued while pipeline busy");
  pat_count_a: assert property (
    acc && st_r == ST_PAT && pat_left_r == 32'h1 |=> st_r == ST_HDR)
    else $error("pattern word count not honoured");

endmodule // dlcd_decoder

//--- verif/dlcd_sink_model.sv
// Purpose: drawing pipeline and pattern sink at the decoder's far side
// Assumes: ready moves only just after a rising edge
// Notes:   slow mode takes one item in three cycles to force stalls
`timescale 1ns/1ps
module dlcd_sink_model
  import dlcd_pkg::*;
#(
  parameter int PRM_WORDS = 9
)(
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire logic                       slow,
  input  wire logic                       prim_valid,
  input  wire dlcd_prim_t                 prim,
  input  wire logic [PRM_WORDS-1:0][31:0] prm,
  input  wire logic                       pat_valid,
  input  wire logic [31:0]                pat_data,
  output logic                            prim_ready,
  output logic                            pat_ready
);
  logic [1:0]                 pace_r;
  dlcd_prim_t                 prim_q[$];
  logic [PRM_WORDS-1:0][31:0] prm_q[$];
  logic [31:0]                pat_q[$];

  // pace counter; slow keeps each ready low two cycles in three
  always_ff @(posedge clock)
  begin
    if (rst || pace_r == 2'h2)
      pace_r <= 2'h0;
    else
      pace_r <= pace_r + 2'h1;
  end
  assign prim_ready = !slow || pace_r == 2'h0;
  assign pat_ready  = !slow || pace_r == 2'h1;

  // keep what the pipeline accepts, in arrival order
  always @(posedge clock)
  begin
    if (!rst && prim_valid && prim_ready)
    begin
      prim_q.push_back(prim);
      prm_q.push_back(prm);
    end
    if (!rst && pat_valid && pat_ready)
      pat_q.push_back(pat_data);
  end
endmodule // dlcd_sink_model

//--- verif/display_list_draw_cmd_decoder_test.sv
// Purpose: self-checking bench for the display-list draw decoder
// Assumes: sink model paces the primitive and pattern sides
// Notes:   expected fields come from register values written here
`timescale 1ns/1ps
`define chk(a, b) \
  begin n_checks++; if ((a) !== (b)) begin errors++; \
  $display("ERROR %0t got %h want %h", $time, (a), (b)); end end
module display_list_draw_cmd_decoder_test;
  import dlcd_pkg::*;
  localparam int PW = 9;
  logic                clock = 1'b0;
  logic                rst = 1'b1;
  dlcd_apb_req_t       apb_req = '0;
  dlcd_apb_rsp_t       apb_rsp;
  logic                dl_valid = 1'b0;
  logic [31:0]         dl_word = 32'h0;
  logic                dl_ready;
  logic                prim_valid;
  logic                prim_ready;
  logic                pat_valid;
  logic                pat_ready;
  logic                slow = 1'b0;
  dlcd_prim_t          prim;
  dlcd_prim_t          base;
  logic [PW-1:0][31:0] prm;
  logic [31:0]         pat_data;
  logic [31:0]         rd;
  logic                err;
  int                  errors = 0;
  int                  n_checks = 0;

  // 100 MHz core clock
  always #5 clock = ~clock;

  dlcd_decoder #(.PRM_WORDS(PW)) i_dlcd_decoder (
    .clock(clock), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .dl_valid(dl_valid), .dl_word(dl_word), .dl_ready(dl_ready),
    .prim_valid(prim_valid), .prim_ready(prim_ready), .prim(prim),
    .prm(prm), .pat_valid(pat_valid), .pat_data(pat_data),
    .pat_ready(pat_ready));

  dlcd_sink_model #(.PRM_WORDS(PW)) i_dlcd_sink_model (
    .clock(clock), .rst(rst), .slow(slow), .prim_valid(prim_valid),
    .prim(prim), .prm(prm), .pat_valid(pat_valid), .pat_data(pat_data),
    .prim_ready(prim_ready), .pat_ready(pat_ready));

  // fetching must pause while a primitive waits for the pipeline
  always @(negedge clock)
  begin
    if (!rst && prim_valid === 1'b1)
      `chk(dl_ready, 1'b0)
  end

  task automatic test_done();
  begin
    if (errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask

  // one apb transfer; request held until the edge that sees pready high,
  // data taken there; one idle edge keeps back-to-back calls apart
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
  begin
    apb_req <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a, pwdata:d};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    do
      @(posedge clock);
    while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge clock);
  end
  endtask

  // valid stays up between words; a word goes at the edge seeing ready,
  // and one idle edge after the last keeps valid from toggling in a step
  task automatic send(input logic [31:0] q[$]);
  begin
    foreach (q[i])
    begin
      dl_valid <= 1'b1;
      dl_word <= q[i];
      do
        @(posedge clock);
      while (dl_ready !== 1'b1);
    end
    dl_valid <= 1'b0;
    @(posedge clock);
  end
  endtask

  function automatic dlcd_prim_t mk(input dlcd_kind_t k);
  begin
    mk = base;
    mk.kind = k;
  end
  endfunction

  // send a command, then judge the primitive, its words and patterns
  task automatic run(input dlcd_prim_t e, input logic [31:0] q[$],
                     input int np);
    int n;
  begin
    send(q);
    n = 0;
    while (n < 100 && (i_dlcd_sink_model.prim_q.size() == 0 ||
           i_dlcd_sink_model.pat_q.size() < q.size() - 1 - np))
    begin
      @(posedge clock);
      n++;
    end
    `chk(i_dlcd_sink_model.prim_q.size(), 1)
    `chk(i_dlcd_sink_model.prim_q[0], e)
    for (int k = 0; k < np; k++)
      `chk(i_dlcd_sink_model.prm_q[0][k], q[k+1])
    `chk(i_dlcd_sink_model.pat_q.size(), q.size() - 1 - np)
    foreach (i_dlcd_sink_model.pat_q[k])
      `chk(i_dlcd_sink_model.pat_q[k], q[k+1+np])
    i_dlcd_sink_model.prim_q.delete();
    i_dlcd_sink_model.prm_q.delete();
    i_dlcd_sink_model.pat_q.delete();
  end
  endtask

  task automatic t_regs();
  begin
    apb(1'b0, REG_CTRL, 32'h0);
    `chk(rd, CTRL_RST)
    apb(1'b0, REG_FRAME_X_RES, 32'h0);
    `chk(rd[15:0], FRAME_X_RES_RST)
    apb(1'b1, REG_COLOR, 32'h00a5_5a3c);
    apb(1'b1, REG_FG, 32'h0000_ff00);
    apb(1'b1, REG_BG, 32'h0000_00ff);
    apb(1'b1, REG_FRAME_X_RES, 32'h0000_0280);
    apb(1'b1, REG_CTRL, 32'h0000_0007);
    apb(1'b0, REG_COLOR, 32'h0);
    `chk(rd, 32'h00a5_5a3c)
    `chk(err, 1'b0)
    apb(1'b1, REG_STATUS, 32'hffff_ffff);
    apb(1'b0, REG_STATUS, 32'h0);
    `chk(rd, 32'h0000_0001)
    apb(1'b0, 8'h40, 32'h0);
    `chk(err, 1'b1)
    `chk(rd, 32'h0)
    base = '0;
    base.color = 32'h00a5_5a3c;
    base.fg = 32'h0000_ff00;
    base.bg = 32'h0000_00ff;
    base.frame_x_resolution = 16'h0280;
    base.bpp16 = 1'b1;
    base.transparent_bg = 1'b1;
  end
  endtask

  // every option mix; the slower half also stalls the pipeline
  task automatic t_lines();
    dlcd_prim_t e;
  begin
    for (int i = 0; i < 16; i++)
    begin
      slow <= (i > 7);
      e = mk(PK_LINE);
      e.reverse = i[0];
      e.skip_last = i[1];
      e.dash_restart = i[2];
      e.smooth = i[3];
      run(e, '{{OP_LINEP, 3'b001, i[3], 1'b0, i[2:0], 16'h0},
          {i[15:0], ~i[15:0]}}, 1);
    end
  end
  endtask

  task automatic t_tri();
    dlcd_prim_t e;
    logic [31:0] q[$];
  begin
    for (int v = 0; v < 2; v++)
    begin
      e = mk(PK_TRAP);
      e.left_tri = v[0];
      q = '{{OP_TRAP, v[0] ? CMD_TRAP_LEFT : CMD_TRAP_RIGHT, 16'h0}};
      for (int k = 0; k < 9; k++)
        q.push_back(32'h7000_0000 + k * 32'h0001_0003 + v);
      run(e, q, 9);
    end
    for (int i = 0; i < 4; i++)
    begin
      e = mk(PK_FAN);
      e.to_flag_buf = i[0];
      q = '{{i[1] ? OP_VTXP : OP_VTX, i[0] ? CMD_FLAG_FAN : CMD_FAN,
             16'h0}, {16'h0031, 16'h0052 + 16'(i)}};
      if (!i[1])
        q.push_back(32'h0077_0000);
      run(e, q, i[1] ? 1 : 2);
    end
  end
  endtask

  task automatic t_rect();
    dlcd_prim_t e;
  begin
    e = mk(PK_RECT);
    e.ignore_clip = 1'b1;
    run(e, '{{OP_RECTP, CMD_SOLID_FILL, 16'h0}, 32'h0010_0023,
        32'h0008_0031}, 2);
    e.flag_clear = 1'b1;
    run(e, '{{OP_RECTP, CMD_FLAG_CLEAR, 16'h0}, 32'h0005_0040,
        32'h0009_0080}, 2);
    run(mk(PK_FINISH), '{{OP_DRAW, CMD_SHAPE_FINISH, 16'h0}}, 0);
  end
  endtask

  // patterns drain one by one while the sink stalls
  task automatic t_pat();
    dlcd_prim_t e;
  begin
    slow <= 1'b1;
    e = mk(PK_PAT);
    run(e, '{{OP_PATP, CMD_BLOCK_PAT, 16'h0003}, 32'h0002_0004,
        32'h0001_07e0, 32'h1111_2222, 32'h3333_4444,
        32'h5555_6666}, 2);
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    base.bpp16 = 1'b0;
    base.transparent_bg = 1'b0;
    e = mk(PK_PAT);
    e.binary_char = 1'b1;
    run(e, '{{OP_PATP, CMD_BIN_CHAR, 16'h0002}, 32'h0002_0004,
        32'h0010_0020, 32'hf0f0_0f0f, 32'h8001_7ffe}, 2);
    e = mk(PK_PAT);
    run(e, '{{OP_LPATP, CMD_BLOCK_PAT, 16'h0}, 32'h0000_0002,
        32'h0003_0005, 32'h0001_0040, 32'hdead_0001,
        32'h0bad_0002}, 3);
    run(e, '{{OP_LPATP, CMD_BLOCK_PAT, 16'h0}, 32'hffff_ffff,
        32'h0003_0005, 32'h0001_0040}, 3);
    slow <= 1'b0;
  end
  endtask

  // bad headers are taken alone and counted; decoding carries on
  task automatic t_bad();
  begin
    send('{32'hff00_0000});
    send('{{OP_DRAW, 8'h01, 16'h0}});
    `chk(i_dlcd_sink_model.prim_q.size(), 0)
    run(mk(PK_FINISH), '{{OP_DRAW, CMD_SHAPE_FINISH, 16'h0}}, 0);
    apb(1'b0, REG_STATUS, 32'h0);
    `chk(rd[15:8], 8'h02)
  end
  endtask

  initial
  begin
    repeat (6) @(posedge clock);
    `chk(dl_ready, 1'b0)
    rst <= 1'b0;
    @(posedge clock);
    t_regs();
    t_lines();
    t_tri();
    t_rect();
    t_pat();
    t_bad();
    test_done();
  end

  // cut a hang short; the full run needs a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge clock);
    errors++;
    test_done();
  end
endmodule // display_list_draw_cmd_decoder_test
